// ---- logic/scca_consts.svh ----
// Constants of the card command acceptance block: register indices,
// field positions, reset values, command class codes and timing counts.
// Assumes inclusion by the top module only.
`ifndef SCCA_CONSTS_SVH
`define SCCA_CONSTS_SVH

// =====================================================================
// Register indices (byte address = index * 4)
`define SCCA_IDX_ERR      4'h1
`define SCCA_IDX_CNT      4'h2
`define SCCA_IDX_SECT     4'h3
`define SCCA_IDX_CYL_LO   4'h4
`define SCCA_IDX_CYL_HI   4'h5
`define SCCA_IDX_DH       4'h6
`define SCCA_IDX_CMD      4'h7
`define SCCA_IDX_CTL      4'hE
`define SCCA_ADDR_IDX     5:2
`define SCCA_ADDR_HIGH    7:6

// =====================================================================
// Field positions
`define SCCA_DH_LBA       6
`define SCCA_DH_DRV       4
`define SCCA_DH_HEAD      3:0
`define SCCA_ST_BSY       7
`define SCCA_ST_RDY       6
`define SCCA_ST_DWF       5
`define SCCA_ST_DSC       4
`define SCCA_ST_DRQ       3
`define SCCA_ST_ERR       0
`define SCCA_ER_ABRT      2
`define SCCA_CTL_SRST     2

// =====================================================================
// Values
`define SCCA_CNT_RST      8'h01
`define SCCA_CNT_STANDBY  8'h00
`define SCCA_CNT_IDLE     8'hFF
`define SCCA_CNT_ZERO     8'h00
`define SCCA_CNT_FULL     9'h100
`define SCCA_STAT_BUSY    8'h80
`define SCCA_CLS_1        2'h1
`define SCCA_CLS_2        2'h2
`define SCCA_CLS_3        2'h3

// =====================================================================
// Timing
`define SCCA_CLK_NS       20
`define SCCA_BSY_MAX_NS   400
`define SCCA_DRQ_C2_US    700
`define SCCA_DRQ_C3_MS    20
`define SCCA_BSY_MAX_CYC  (`SCCA_BSY_MAX_NS / `SCCA_CLK_NS)
`define SCCA_DRQ_C2_CYC   ((`SCCA_DRQ_C2_US * 1000) / `SCCA_CLK_NS)
`define SCCA_DRQ_C3_CYC   ((`SCCA_DRQ_C3_MS * 1000000) / `SCCA_CLK_NS)

`endif

// ---- logic/scca_pkg.sv ----
// Types of the card command acceptance block.
// Assumes the constants header sits beside it.
`default_nettype none

package scca_pkg;

	// =================================================================
	// Enumerations
	typedef enum logic [1:0] {
		SCCA_PWR_IDLE,
		SCCA_PWR_STANDBY,
		SCCA_PWR_TO_STANDBY,
		SCCA_PWR_FROM_STANDBY
	} scca_power_type;

	typedef enum logic [2:0] {
		ST_IDLE,
		ST_LOOKUP,
		ST_DECODE,
		ST_EXEC,
		ST_PREP,
		ST_XFER
	} scca_fsm_type;

	// =================================================================
	// Carriers
	typedef struct packed {
		logic       known;
		logic [1:0] cls;
		logic       nop;
		logic       pwr;
		logic       fr;
		logic       sc;
		logic       sn;
		logic       cy;
		logic       dhf;
		logic       lba_ok;
	} scca_rom_type;

	typedef struct packed {
		logic [7:0]  code;
		logic [1:0]  cls;
		logic        lba;
		logic        drive;
		logic [27:0] addr;
		logic        addr_valid;
		logic [8:0]  count;
		logic        count_valid;
		logic [7:0]  feature;
		logic        feature_valid;
	} scca_cmd_type;

	typedef struct packed {
		logic done;
		logic fail;
		logic fault;
	} scca_done_type;

	typedef struct packed {
		scca_fsm_type st;
		logic [7:0]   feat;
		logic [7:0]   cnt;
		logic [7:0]   sect;
		logic [7:0]   cyl_lo;
		logic [7:0]   cyl_hi;
		logic [7:0]   dh;
		logic [7:0]   code;
		logic [7:0]   err_reg;
		logic         busy;
		logic         rdy;
		logic         write_fault_flag;
		logic         drq;
		logic         err;
		logic         srst;
		logic [19:0]  timer;
		logic [31:0]  prdata;
		scca_cmd_type cmd;
		logic         start;
		logic         abort;
		logic         irq;
	} scca_state_type;

endpackage : scca_pkg

`default_nettype wire

// ---- logic/scca_cmd_rom.sv ----
// Command attribute table: one entry per command code, read data
// registered. Assumes the code input is stable for one cycle.
`timescale 1ns/10ps
`default_nettype none

module scca_cmd_rom (
	// Clock and reset
	input  wire logic                  clk_i,
	input  wire logic                  arst_n_i,
	// Lookup
	input  wire logic [7:0]            code_i,
	output scca_pkg::scca_rom_type     info_o
);
	import scca_pkg::*;

	// =================================================================
	// Table
	// Flags: fr sc sn cy dhf lba; unknown codes return all zero
	function automatic scca_rom_type ent(input logic [1:0] c,
		input logic [5:0] f);
		ent = {1'b1, c, 2'h0, f};
	endfunction : ent

	function automatic scca_rom_type lookup(input logic [7:0] code);
		lookup = '0;
		unique casez (code)
			8'h00: lookup = {1'b1, 2'h1, 2'h2, 6'h00};
			8'h98, 8'hE5: lookup = {1'b1, 2'h1, 2'h1, 6'h00};
			8'hC0, 8'hC8, 8'hC4, 8'h20, 8'h21, 8'h40, 8'h41,
			8'hF9, 8'h87: lookup = ent(2'h1, 6'h1F);
			8'h90, 8'hE7, 8'hEC, 8'hE1, 8'h95, 8'hE4, 8'hF8,
			8'h03, 8'hE6, 8'h99, 8'hE2, 8'h96, 8'hE0, 8'h94,
			8'b0001????: lookup = ent(2'h1, 6'h00);
			8'h50: lookup = ent(2'h2, 6'h17);
			8'hE3, 8'h97, 8'hC6: lookup = ent(2'h1, 6'h10);
			8'h91: lookup = ent(2'h1, 6'h12);
			8'b0111????: lookup = ent(2'h1, 6'h0F);
			8'hEF: lookup = ent(2'h1, 6'h20);
			8'hB0: lookup = ent(2'h1, 6'h34);
			8'hF5: lookup = ent(2'h1, 6'h02);
			8'hE8: lookup = ent(2'h2, 6'h00);
			8'hCA, 8'h30, 8'h31, 8'h38: lookup = ent(2'h2, 6'h1F);
			8'hC5, 8'hCD, 8'h3C: lookup = ent(2'h3, 6'h1F);
			default: lookup = '0;
		endcase
	endfunction : lookup

	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			info_o <= '0;
		end else begin
			info_o <= lookup(code_i);
		end
	end

endmodule : scca_cmd_rom

`default_nettype wire

// ---- logic/scca_top.sv ----
// Command acceptance of the card task file, reached over APB.
// Assumes a back end that prepares the buffer and executes commands,
// and a power manager on the same clock.
//
// Summary of operation
// - First class sets busy within 400 ns
// - Second class: buffer, request within 700 us
// - Third class: request within 20 ms
// - Legacy no-operation code completes doing nothing
// - Multiple-write codes are third class, addressed
// - Single-sector write codes are second class
// - Native max read and set max first class
// - Drive-only commands ignore the head field
// - Full commands pass drive and head field
// - Power query in standby loads zero count
// - Power query when idle loads all ones
// - Erase has no transfer, may fault
// - Erase takes start address and count
// - Zero sector count means 256 sectors
// - Head bit 6 selects block addressing
// - Busy hides status and blocks task file writes; control stays writable
// - Block addressing only where command allows
//
// Design decisions made here: register access over APB and the register offsets.
`timescale 1ns/10ps
`default_nettype none
`include "scca_consts.svh"

module scca_top #(
	parameter int unsigned DRQ_C2_CYC = `SCCA_DRQ_C2_CYC,
	parameter int unsigned DRQ_C3_CYC = `SCCA_DRQ_C3_CYC
) (
	// Clock and reset
	input  wire logic                  clk_i,
	input  wire logic                  arst_n_i,
	// APB slave
	input  wire logic                  psel_i,
	input  wire logic                  penable_i,
	input  wire logic                  pwrite_i,
	input  wire logic [7:0]            paddr_i,
	input  wire logic [31:0]           pwdata_i,
	output logic [31:0]                prdata_o,
	output logic                       pready_o,
	output logic                       pslverr_o,
	// Power manager
	input  wire scca_pkg::scca_power_type power_mode_i,
	// Back end
	input  wire logic                  buf_ready_i,
	input  wire scca_pkg::scca_done_type done_i,
	output scca_pkg::scca_cmd_type     cmd_o,
	output logic                       cmd_start_o,
	output logic                       cmd_abort_o,
	// Status
	output logic                       busy_o,
	output logic                       drq_o,
	output logic                       irq_o
);
	import scca_pkg::*;

	localparam int BSY_MAX = `SCCA_BSY_MAX_CYC;
	localparam scca_state_type RST_STATE = '{
		st: ST_IDLE, cnt: `SCCA_CNT_RST, default: '0};

	scca_state_type s_ff;
	scca_state_type nxt_s;
	scca_rom_type   info;
	logic [3:0]     idx;
	logic           setup;
	logic           access;
	logic           tf_write;
	logic           refused;
	logic           wr_ok;
	logic [19:0]    lim;

	// =================================================================
	// Helpers
	function automatic logic [7:0] status_byte(input scca_state_type s);
		status_byte = '0;
		if (s.busy) begin
			status_byte = `SCCA_STAT_BUSY;
		end else begin
			status_byte[`SCCA_ST_RDY] = s.rdy;
			status_byte[`SCCA_ST_DWF] = s.write_fault_flag;
			status_byte[`SCCA_ST_DSC] = s.rdy;
			status_byte[`SCCA_ST_DRQ] = s.drq;
			status_byte[`SCCA_ST_ERR] = s.err;
		end
	endfunction : status_byte

	function automatic logic mapped(input logic [7:0] a);
		logic [3:0] i;
		i = a[`SCCA_ADDR_IDX];
		mapped = (a[`SCCA_ADDR_HIGH] == 2'h0) && (a[1:0] == 2'h0) &&
			((i >= `SCCA_IDX_ERR && i <= `SCCA_IDX_CMD) ||
			 i == `SCCA_IDX_CTL);
	endfunction : mapped

	function automatic logic [31:0] read_word(input scca_state_type s,
		input logic [3:0] i);
		logic [7:0] b;
		b = '0;
		case (i)
			`SCCA_IDX_ERR:    b = s.err_reg;
			`SCCA_IDX_CNT:    b = s.cnt;
			`SCCA_IDX_SECT:   b = s.sect;
			`SCCA_IDX_CYL_LO: b = s.cyl_lo;
			`SCCA_IDX_CYL_HI: b = s.cyl_hi;
			`SCCA_IDX_DH:     b = s.dh;
			`SCCA_IDX_CMD,
			`SCCA_IDX_CTL:    b = status_byte(s);
			default:          b = '0;
		endcase
		read_word = {24'h0, b};
	endfunction : read_word

	// Address, feature and block mode are gated by the table entry; drive and count pass as loaded
	function automatic scca_cmd_type build_cmd(input scca_state_type s,
		input scca_rom_type f);
		scca_cmd_type c;
		c = '0;
		c.code  = s.code;
		c.cls   = f.cls;
		c.lba   = f.lba_ok & s.dh[`SCCA_DH_LBA];
		c.drive = s.dh[`SCCA_DH_DRV];
		// Drive-only commands mask the head nibble to zero
		c.addr[27:24] = f.dhf ? s.dh[`SCCA_DH_HEAD] : 4'h0;
		c.addr[23:8]  = f.cy ? {s.cyl_hi, s.cyl_lo} : 16'h0;
		c.addr[7:0]   = f.sn ? s.sect : 8'h0;
		c.addr_valid  = f.sn | f.cy;
		c.count = (s.cnt == `SCCA_CNT_ZERO) ? `SCCA_CNT_FULL :
			{1'b0, s.cnt};
		c.count_valid   = f.sc;
		c.feature       = f.fr ? s.feat : 8'h0;
		c.feature_valid = f.fr;
		build_cmd = c;
	endfunction : build_cmd

	// =================================================================
	// Command table
	scca_cmd_rom u_rom (
		.clk_i    (clk_i),
		.arst_n_i (arst_n_i),
		.code_i   (s_ff.code),
		.info_o   (info)
	);

	// =================================================================
	// APB decode
	// Zero wait states: read data is captured in the setup cycle
	assign idx      = paddr_i[`SCCA_ADDR_IDX];
	assign setup    = psel_i & ~penable_i;
	assign access   = psel_i & penable_i;
	assign tf_write = pwrite_i && idx != `SCCA_IDX_CTL;
	// Task file is the card's own while busy; control stays writable
	assign refused  = !mapped(paddr_i) || (tf_write && s_ff.busy);
	assign wr_ok    = access & pwrite_i & ~refused;
	assign pready_o  = access;
	assign pslverr_o = access & refused;
	assign lim = (s_ff.cmd.cls == `SCCA_CLS_3) ? DRQ_C3_CYC[19:0] :
		DRQ_C2_CYC[19:0];

	// =================================================================
	// Next state
	always_comb begin
		nxt_s = s_ff;
		nxt_s.start = 1'b0;
		nxt_s.abort = 1'b0;
		nxt_s.irq   = 1'b0;
		nxt_s.rdy   = 1'b1;
		if (setup) begin
			nxt_s.prdata = mapped(paddr_i) ? read_word(s_ff, idx) : '0;
		end
		unique case (s_ff.st)
			ST_IDLE: begin
			end
			ST_LOOKUP: begin
				nxt_s.st = ST_DECODE;
			end
			ST_DECODE: begin
				nxt_s.st = ST_IDLE;
				if (!info.known) begin
					nxt_s.err = 1'b1;
					nxt_s.err_reg[`SCCA_ER_ABRT] = 1'b1;
					nxt_s.busy = 1'b0;
					nxt_s.irq  = 1'b1;
				end else if (info.pwr) begin
					nxt_s.cnt = (power_mode_i == SCCA_PWR_IDLE) ?
						`SCCA_CNT_IDLE : `SCCA_CNT_STANDBY;
					nxt_s.busy = 1'b0;
					nxt_s.irq  = 1'b1;
				end else if (info.nop) begin
					nxt_s.busy = 1'b0;
					nxt_s.irq  = 1'b1;
				end else begin
					nxt_s.cmd   = build_cmd(s_ff, info);
					nxt_s.start = 1'b1;
					nxt_s.timer = '0;
					// Erase and other first-class commands have no transfer
					nxt_s.st = (info.cls == `SCCA_CLS_1) ? ST_EXEC :
						ST_PREP;
				end
			end
			ST_EXEC: begin
				if (done_i.done) begin
					nxt_s.busy = 1'b0;
					nxt_s.err  = done_i.fail;
					nxt_s.err_reg[`SCCA_ER_ABRT] = done_i.fail;
					nxt_s.write_fault_flag  = done_i.fault;
					nxt_s.irq  = 1'b1;
					nxt_s.st   = ST_IDLE;
				end
			end
			ST_PREP: begin
				nxt_s.timer = s_ff.timer + 20'h1;
				if (buf_ready_i) begin
					// Busy drops on the same edge that raises the request
					nxt_s.drq  = 1'b1;
					nxt_s.busy = 1'b0;
					nxt_s.st   = ST_XFER;
				end else if (s_ff.timer >= lim - 20'h1) begin
					// A late buffer is aborted rather than overrunning
					nxt_s.abort = 1'b1;
					nxt_s.err   = 1'b1;
					nxt_s.err_reg[`SCCA_ER_ABRT] = 1'b1;
					nxt_s.busy  = 1'b0;
					nxt_s.irq   = 1'b1;
					nxt_s.st    = ST_IDLE;
				end
			end
			ST_XFER: begin
				if (done_i.done) begin
					nxt_s.drq = 1'b0;
					nxt_s.err = done_i.fail;
					nxt_s.err_reg[`SCCA_ER_ABRT] = done_i.fail;
					nxt_s.write_fault_flag = done_i.fault;
					nxt_s.irq = 1'b1;
					nxt_s.st  = ST_IDLE;
				end
			end
		endcase
		if (wr_ok) begin
			case (idx)
				`SCCA_IDX_ERR:    nxt_s.feat   = pwdata_i[7:0];
				`SCCA_IDX_CNT:    nxt_s.cnt    = pwdata_i[7:0];
				`SCCA_IDX_SECT:   nxt_s.sect   = pwdata_i[7:0];
				`SCCA_IDX_CYL_LO: nxt_s.cyl_lo = pwdata_i[7:0];
				`SCCA_IDX_CYL_HI: nxt_s.cyl_hi = pwdata_i[7:0];
				`SCCA_IDX_DH:     nxt_s.dh     = pwdata_i[7:0];
				`SCCA_IDX_CTL:    nxt_s.srst = pwdata_i[`SCCA_CTL_SRST];
				default: begin
				end
			endcase
			// The code write is the start; parameters were loaded before
			if (idx == `SCCA_IDX_CMD) begin
				nxt_s.code    = pwdata_i[7:0];
				nxt_s.busy    = 1'b1;
				nxt_s.drq     = 1'b0;
				nxt_s.err     = 1'b0;
				nxt_s.write_fault_flag     = 1'b0;
				nxt_s.err_reg = '0;
				nxt_s.abort   = (s_ff.st == ST_XFER);
				nxt_s.st      = ST_LOOKUP;
			end
		end
		// Soft reset holds the machine in its reset values
		if (s_ff.srst) begin
			nxt_s        = RST_STATE;
			nxt_s.srst   = wr_ok && idx == `SCCA_IDX_CTL ?
				pwdata_i[`SCCA_CTL_SRST] : 1'b1;
			nxt_s.prdata = setup ? read_word(s_ff, idx) : s_ff.prdata;
			nxt_s.abort  = (s_ff.st != ST_IDLE);
		end
	end

	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			s_ff <= RST_STATE;
		end else begin
			s_ff <= nxt_s;
		end
	end

	assign prdata_o    = s_ff.prdata;
	assign cmd_o       = s_ff.cmd;
	assign cmd_start_o = s_ff.start;
	assign cmd_abort_o = s_ff.abort;
	assign busy_o      = s_ff.busy;
	assign drq_o       = s_ff.drq;
	assign irq_o       = s_ff.irq;

	// =================================================================
	// Assertions
	a_busy_on_cmd: assert property (
		@(posedge clk_i) disable iff (!arst_n_i)
		wr_ok && idx == `SCCA_IDX_CMD && !s_ff.srst
		|-> ##[1:BSY_MAX] busy_o)
		else $error("busy not raised after command write");

	a_drq_drops_busy: assert property (
		@(posedge clk_i) disable iff (!arst_n_i)
		$rose(drq_o) |-> !busy_o && $past(s_ff.st) == ST_PREP)
		else $error("busy still set when data request rose");

	a_prep_bound: assert property (
		@(posedge clk_i) disable iff (!arst_n_i)
		s_ff.st == ST_PREP |-> s_ff.timer < lim)
		else $error("data request wait overran its limit");

	a_nop_quiet: assert property (
		@(posedge clk_i) disable iff (!arst_n_i || s_ff.srst)
		s_ff.st == ST_DECODE && info.known && info.nop
		|=> !busy_o && irq_o && !cmd_start_o && !s_ff.err)
		else $error("no-operation code did not complete quietly");

	a_wr_multi_cls: assert property (
		@(posedge clk_i) disable iff (!arst_n_i || s_ff.srst)
		s_ff.st == ST_DECODE &&
		(s_ff.code == 8'hC5 || s_ff.code == 8'hCD)
		|=> cmd_start_o && cmd_o.cls == `SCCA_CLS_3 &&
			s_ff.st == ST_PREP)
		else $error("multiple write not third class");

	a_wr_single_cls: assert property (
		@(posedge clk_i) disable iff (!arst_n_i || s_ff.srst)
		s_ff.st == ST_DECODE && (s_ff.code == 8'h30 ||
		s_ff.code == 8'h31 || s_ff.code == 8'h38)
		|=> cmd_o.cls == `SCCA_CLS_2 && cmd_o.addr_valid)
		else $error("single write not second class");

	a_max_addr_cls: assert property (
		@(posedge clk_i) disable iff (!arst_n_i || s_ff.srst)
		s_ff.st == ST_DECODE &&
		(s_ff.code == 8'hF8 || s_ff.code == 8'hF9)
		|=> s_ff.st == ST_EXEC && cmd_o.cls == `SCCA_CLS_1 &&
			cmd_o.addr_valid == (cmd_o.code == 8'hF9))
		else $error("max address command misdecoded");

	a_head_mask: assert property (
		@(posedge clk_i) disable iff (!arst_n_i || s_ff.srst)
		cmd_start_o && !$past(info.dhf) |-> cmd_o.addr[27:24] == 4'h0)
		else $error("head field passed for drive-only command");

	a_head_full: assert property (
		@(posedge clk_i) disable iff (!arst_n_i || s_ff.srst)
		cmd_start_o && $past(info.dhf)
		|-> cmd_o.addr[27:24] == $past(s_ff.dh[`SCCA_DH_HEAD]) &&
			cmd_o.drive == $past(s_ff.dh[`SCCA_DH_DRV]))
		else $error("head field lost for full command");

	a_pwr_standby: assert property (
		@(posedge clk_i) disable iff (!arst_n_i || s_ff.srst)
		s_ff.st == ST_DECODE && info.pwr && info.known &&
		power_mode_i != SCCA_PWR_IDLE
		|=> s_ff.cnt == `SCCA_CNT_STANDBY && !busy_o && irq_o)
		else $error("standby power query result wrong");

	a_pwr_idle: assert property (
		@(posedge clk_i) disable iff (!arst_n_i || s_ff.srst)
		s_ff.st == ST_DECODE && info.pwr && info.known &&
		power_mode_i == SCCA_PWR_IDLE
		|=> s_ff.cnt == `SCCA_CNT_IDLE && !busy_o && irq_o)
		else $error("idle power query result wrong");

	a_erase_fault: assert property (
		@(posedge clk_i) disable iff (!arst_n_i || s_ff.srst)
		s_ff.st == ST_EXEC && done_i.done |=> s_ff.write_fault_flag ==
			$past(done_i.fault) && !drq_o && !busy_o)
		else $error("erase completion status wrong");

	a_count_full: assert property (
		@(posedge clk_i) disable iff (!arst_n_i || s_ff.srst)
		cmd_start_o && $past(s_ff.cnt) == `SCCA_CNT_ZERO
		|-> cmd_o.count == `SCCA_CNT_FULL)
		else $error("zero count not read as 256");

	a_lba_gate: assert property (
		@(posedge clk_i) disable iff (!arst_n_i || s_ff.srst)
		cmd_start_o |-> cmd_o.lba ==
			($past(info.lba_ok) && $past(s_ff.dh[`SCCA_DH_LBA])))
		else $error("addressing mode bit misapplied");

	a_busy_hides: assert property (
		@(posedge clk_i) disable iff (!arst_n_i)
		setup && s_ff.busy && paddr_i == {2'h0, `SCCA_IDX_CMD, 2'h0}
		|=> prdata_o == {24'h0, `SCCA_STAT_BUSY})
		else $error("status bits visible while busy");

	a_unknown_abort: assert property (
		@(posedge clk_i) disable iff (!arst_n_i || s_ff.srst)
		s_ff.st == ST_DECODE && !info.known
		|=> !busy_o && s_ff.err && s_ff.err_reg[`SCCA_ER_ABRT])
		else $error("unknown code not aborted");

endmodule : scca_top

`default_nettype wire

// ---- verif/scca_host_model.sv ----
// Host model: an APB master that loads the card task file.
// Assumes one clock shared with the card logic.
`timescale 1ns/10ps
`default_nettype none

module scca_host_model (
	// Clock
	input  wire logic        clk_i,
	// APB master
	output logic             psel_o,
	output logic             penable_o,
	output logic             pwrite_o,
	output logic [7:0]       paddr_o,
	output logic [31:0]      pwdata_o,
	input  wire logic [31:0] prdata_i,
	input  wire logic        pready_i,
	input  wire logic        pslverr_i
);
	logic hung;

	initial begin
		psel_o = 1'b0;
		penable_o = 1'b0;
		pwrite_o = 1'b0;
		paddr_o = 8'h00;
		pwdata_o = 32'h0;
		hung = 1'b0;
	end

	// =========
	// Transfer
	// Request held until pready is sampled; released bus shows inverse
	task automatic xfer(input logic w, input logic [7:0] a, d,
		output logic [7:0] r, output logic e);
		int n;
		@(posedge clk_i);
		psel_o <= 1'b1;
		pwrite_o <= w;
		paddr_o <= a;
		pwdata_o <= {24'h0, d};
		@(posedge clk_i);
		penable_o <= 1'b1;
		for (n = 0; n < 8; n++) begin
			@(posedge clk_i);
			if (pready_i === 1'b1)
				break;
		end
		hung = (n == 8);
		r = prdata_i[7:0];
		e = pslverr_i;
		psel_o <= 1'b0;
		penable_o <= 1'b0;
		paddr_o <= ~a;
		pwdata_o <= ~{24'h0, d};
	endtask : xfer
endmodule : scca_host_model

`default_nettype wire

// ---- verif/tb_top.sv ----
// Self-checking bench of the card command acceptance block.
// Assumes the host model is compiled before this file.
`timescale 1ns/10ps
`default_nettype none

module tb_top;
	import scca_pkg::*;

	// =========
	// Signals
	localparam int unsigned C2 = 20;
	localparam int unsigned C3 = 40;
	logic           clk_i;
	logic           arst_n_i;
	logic           psel, penable, pwrite, pready, pslverr;
	logic [7:0]     paddr, r;
	logic [31:0]    pwdata, prdata;
	logic           e, buf_ready_i, cmd_start, cmd_abort, busy, drq, irq;
	scca_power_type power_mode_i;
	scca_done_type  done_i;
	scca_cmd_type   cmd, seen_cmd;
	int             failures, comparisons, irqs, starts, aborts;

	scca_top #(.DRQ_C2_CYC(C2), .DRQ_C3_CYC(C3)) dut (
		.clk_i(clk_i), .arst_n_i(arst_n_i), .psel_i(psel),
		.penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
		.pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
		.pslverr_o(pslverr), .power_mode_i(power_mode_i),
		.buf_ready_i(buf_ready_i), .done_i(done_i), .cmd_o(cmd),
		.cmd_start_o(cmd_start), .cmd_abort_o(cmd_abort),
		.busy_o(busy), .drq_o(drq), .irq_o(irq));

	scca_host_model host (.clk_i(clk_i), .psel_o(psel),
		.penable_o(penable), .pwrite_o(pwrite), .paddr_o(paddr),
		.pwdata_o(pwdata), .prdata_i(prdata), .pready_i(pready),
		.pslverr_i(pslverr));

	// Pulses are counted so that no one-cycle event is missed
	always @(posedge clk_i) begin
		if (irq === 1'b1)
			irqs++;
		if (cmd_abort === 1'b1)
			aborts++;
		if (cmd_start === 1'b1) begin
			starts++;
			seen_cmd = cmd;
		end
	end

	// =========
	// Helpers
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", comparisons, failures);
		if (failures == 0 && comparisons > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : report_and_stop

	task automatic check(input string what, input logic [63:0] seen, exp);
		comparisons++;
		if (seen !== exp) begin
			failures++;
			$display("ERROR %s expected %0h seen %0h", what, exp, seen);
		end
	endtask : check

	task automatic acc(input logic w, input logic [7:0] a, d);
		host.xfer(w, a, d, r, e);
		if (host.hung) begin
			failures++;
			report_and_stop();
		end
	endtask : acc

	task automatic rd_chk(input string what, input logic [7:0] a, exp);
		acc(1'b0, a, 8'h00);
		check(what, r, exp);
	endtask : rd_chk

	task automatic wait_busy(input logic lvl, input int lim);
		for (int n = 0; n < lim && busy !== lvl; n++)
			@(negedge clk_i);
		if (busy !== lvl) begin
			failures++;
			report_and_stop();
		end
	endtask : wait_busy

	// Count 00h asks for 256 sectors
	task automatic load(input logic [7:0] dh);
		acc(1'b1, 8'h08, 8'h00);
		acc(1'b1, 8'h0C, 8'h12);
		acc(1'b1, 8'h10, 8'h34);
		acc(1'b1, 8'h14, 8'h56);
		acc(1'b1, 8'h18, dh);
	endtask : load

	task automatic issue(input logic [7:0] code);
		wait_busy(1'b0, 2000);
		acc(1'b1, 8'h1C, code);
		check("cmd refused", e, 1'b0);
		wait_busy(1'b1, 20);
	endtask : issue

	task automatic complete(input logic [1:0] cl, input logic f,
		input logic [7:0] st);
		int i0;
		i0 = irqs;
		if (cl != 2'h1) begin
			@(posedge clk_i);
			buf_ready_i <= 1'b1;
			for (int n = 0; n < 20 && drq !== 1'b1; n++)
				@(negedge clk_i);
			check("drq", drq, 1'b1);
			check("busy at drq", busy, 1'b0);
		end else
			check("no drq", drq, 1'b0);
		@(posedge clk_i);
		done_i <= {1'b1, 1'b0, f};
		@(posedge clk_i);
		done_i <= '0;
		buf_ready_i <= 1'b0;
		repeat (3) @(negedge clk_i);
		check("irq count", irqs - i0, 1);
		check("drq end", drq, 1'b0);
		rd_chk("status", 8'h1C, st);
	endtask : complete

	// =========
	// Scenarios
	task automatic t_reset();
		rd_chk("count", 8'h08, 8'h01);
		rd_chk("status", 8'h1C, 8'h50);
		rd_chk("alt status", 8'h38, 8'h50);
		rd_chk("unmapped", 8'h20, 8'h00);
		check("unmapped err", e, 1'b1);
		$display("test reset done");
	endtask : t_reset

	task automatic t_power();
		logic [7:0] cd [2] = '{8'h98, 8'hE5};
		int i0;
		for (int m = 0; m < 4; m++) begin
			for (int c = 0; c < 2; c++) begin
				@(posedge clk_i);
				power_mode_i <= scca_power_type'(m);
				i0 = irqs;
				issue(cd[c]);
				wait_busy(1'b0, 10);
				repeat (2) @(negedge clk_i);
				check("power irq", irqs - i0, 1);
				rd_chk("pwr cnt", 8'h08, m == 0 ? 8'hFF : 8'h00);
			end
		end
		$display("test power done");
	endtask : t_power

	task automatic t_nop();
		logic [7:0] cd [2] = '{8'h01, 8'h00};
		logic [7:0] st [2] = '{8'h51, 8'h50};
		int s0;
		for (int i = 0; i < 2; i++) begin
			s0 = starts;
			issue(cd[i]);
			wait_busy(1'b0, 10);
			check("no start", starts - s0, 0);
			rd_chk("status", 8'h1C, st[i]);
			rd_chk("error", 8'h04, st[i][0] ? 8'h04 : 8'h00);
		end
		$display("test nop done");
	endtask : t_nop

	task automatic t_class();
		logic [7:0] cd [7] = '{8'h30, 8'h31, 8'h38, 8'hC5, 8'hCD,
			8'hF9, 8'hC0};
		logic [1:0] cl [7] = '{2'h2, 2'h2, 2'h2, 2'h3, 2'h3, 2'h1, 2'h1};
		for (int i = 0; i < 7; i++) begin
			load(8'hE7);
			issue(cd[i]);
			repeat (4) @(negedge clk_i);
			check("class", seen_cmd.cls, cl[i]);
			check("lba", seen_cmd.lba, 1'b1);
			check("addr", seen_cmd.addr, 28'h7563412);
			check("count", seen_cmd.count, 9'h100);
			acc(1'b1, 8'h0C, 8'hAA);
			check("busy write", e, 1'b1);
			rd_chk("busy status", 8'h1C, 8'h80);
			complete(cl[i], cd[i] == 8'hC0, cd[i] == 8'hC0 ? 8'h70 : 8'h50);
		end
		rd_chk("sector", 8'h0C, 8'h12);
		$display("test class done");
	endtask : t_class

	task automatic t_drv();
		load(8'hFF);
		issue(8'hF8);
		repeat (4) @(negedge clk_i);
		check("drive", seen_cmd.drive, 1'b1);
		check("head dropped", seen_cmd.addr, 28'h0);
		check("no lba", seen_cmd.lba, 1'b0);
		complete(2'h1, 1'b0, 8'h50);
		$display("test drive done");
	endtask : t_drv

	task automatic t_late();
		int a0;
		a0 = aborts;
		load(8'hE7);
		issue(8'hCD);
		wait_busy(1'b0, C3 + 10);
		repeat (2) @(negedge clk_i);
		check("abort pulse", aborts - a0, 1);
		check("drq late", drq, 1'b0);
		rd_chk("status", 8'h1C, 8'h51);
		$display("test late done");
	endtask : t_late

	// Soft reset while a command waits drops it and restores defaults
	task automatic t_srst();
		int a0;
		a0 = aborts;
		issue(8'hF9);
		acc(1'b1, 8'h38, 8'h04);
		check("ctl refused", e, 1'b0);
		rd_chk("srst count", 8'h08, 8'h01);
		check("srst busy", busy, 1'b0);
		acc(1'b1, 8'h38, 8'h00);
		check("srst abort", aborts - a0, 1);
		rd_chk("srst status", 8'h1C, 8'h50);
		$display("test soft reset done");
	endtask : t_srst

	// =========
	// Main
	initial begin
		clk_i = 1'b0;
		forever #10 clk_i = ~clk_i;
	end

	initial begin
		arst_n_i = 1'b0;
		power_mode_i = SCCA_PWR_IDLE;
		buf_ready_i = 1'b0;
		done_i = '0;
		repeat (4) @(posedge clk_i);
		arst_n_i <= 1'b1;
		t_reset();
		t_power();
		t_nop();
		t_class();
		t_drv();
		t_late();
		t_srst();
		report_and_stop();
	end
endmodule : tb_top

`default_nettype wire
